// File: pkg/slb_defs.svh
// shared constants of the lamp bus command responder
`ifndef SLB_DEFS_SVH
`define SLB_DEFS_SVH

// clock and link timing
`define SLB_CLK_HZ        100000000
`define SLB_BAUD          38400
`define SLB_BIT_CYCLES    (`SLB_CLK_HZ / `SLB_BAUD)
`define SLB_GAP_US        1000
`define SLB_GAP_CYCLES    (`SLB_GAP_US * (`SLB_CLK_HZ / 1000000))
`define SLB_HOLD_MS       100
`define SLB_HOLD_CYCLES   (`SLB_HOLD_MS * (`SLB_CLK_HZ / 1000))

// word framing
`define SLB_DATA_BITS     9
`define SLB_ADDR_FLAG     8
`define SLB_PANEL_TOP     8'h10
`define SLB_MAX_SEQ       10
`define SLB_REPLY_LAST    3'h5

// command codes
`define SLB_CMD_PAN_JOG   8'h01
`define SLB_CMD_TILT_JOG  8'h02
`define SLB_CMD_LAMP      8'h0A
`define SLB_CMD_FOCUS     8'h0B
`define SLB_CMD_HOME      8'h0C
`define SLB_CMD_RECORD    8'h0D
`define SLB_CMD_PLAY      8'h0E
`define SLB_CMD_STORE     8'h0F
`define SLB_CMD_PAN_POS   8'h18
`define SLB_CMD_TILT_POS  8'h19

// register byte offsets
`define SLB_REG_CTRL      8'h00
`define SLB_REG_POSITION  8'h04
`define SLB_REG_FLAGS     8'h08
`define SLB_REG_STATE     8'h0C
`define SLB_REG_TARGET    8'h10
`define SLB_REG_JOG       8'h14
`define SLB_REG_ERRORS    8'h18

// reset values
`define SLB_LAMP_ADDR_RST 6'h10
`define SLB_POS_CENTRE    12'h800
`define SLB_SPEED_CENTRE  8'h80

`endif

// File: pkg/slb_pkg.sv
// types of the lamp bus command responder
package slb_pkg;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } slb_rx_state_t;

  typedef enum logic [0:0] {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } slb_tx_state_t;

  typedef enum logic [1:0] {
    PH_IDLE    = 2'b00,
    PH_COLLECT = 2'b01,
    PH_EXEC    = 2'b10,
    PH_REPLY   = 2'b11
  } slb_phase_t;

  typedef struct packed {
    logic [1:0]    sync;
    slb_rx_state_t st;
    logic [15:0]   cnt;
    logic [3:0]    bitn;
    logic [8:0]    shift;
    logic          valid;
    logic [8:0]    data;
  } slb_rx_regs_t;

  typedef struct packed {
    slb_tx_state_t st;
    logic [15:0]   cnt;
    logic [3:0]    bitn;
    logic [10:0]   shift;
    logic          txd;
    logic          oe;
  } slb_tx_regs_t;

endpackage

// File: verilog/slb_word_rx.sv
// nine-bit word receiver with input synchroniser
`timescale 1ns/1ps
`include "slb_defs.svh"
module slb_word_rx #(
  parameter int BIT_CYCLES = `SLB_BIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       rxd,
  output logic            word_valid,
  output logic [8:0]      word_data
);
  import slb_pkg::*;

  slb_rx_regs_t q;
  slb_rx_regs_t next_q;
  logic         line;

  assign line       = q.sync[1];
  assign word_valid = q.valid;
  assign word_data  = q.data;

  //////////////////////////////////////////////////////////////////////////////
  // start bit, nine data bits lsb first, stop bit; a bad stop drops the word
  always_comb begin
    next_q       = q;
    next_q.sync  = {q.sync[0], rxd};
    next_q.valid = 1'b0;
    next_q.cnt   = q.cnt + 16'h0001;
    unique case (q.st)
      RX_IDLE: begin
        next_q.cnt = 16'h0000;
        if (!line) begin
          next_q.st = RX_START;
        end
      end
      RX_START: begin
        // sample mid start bit to reject glitches
        if (q.cnt == 16'(BIT_CYCLES / 2 - 1)) begin
          next_q.cnt  = 16'h0000;
          next_q.bitn = 4'h0;
          next_q.st   = line ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (q.cnt == 16'(BIT_CYCLES - 1)) begin
          next_q.cnt   = 16'h0000;
          next_q.shift = {line, q.shift[8:1]};
          next_q.bitn  = q.bitn + 4'h1;
          if (q.bitn == 4'(`SLB_DATA_BITS - 1)) begin
            next_q.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (q.cnt == 16'(BIT_CYCLES - 1)) begin
          next_q.st = RX_IDLE;
          if (line) begin
            next_q.valid = 1'b1;
            next_q.data  = q.shift;
          end
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '{sync: 2'h3, st: RX_IDLE, cnt: 16'h0000, bitn: 4'h0,
             shift: 9'h000, valid: 1'b0, data: 9'h000};
    end else begin
      q <= next_q;
    end
  end
endmodule

// File: verilog/slb_word_tx.sv
// nine-bit word transmitter driving the shared bus pair
`timescale 1ns/1ps
`include "slb_defs.svh"
module slb_word_tx #(
  parameter int BIT_CYCLES = `SLB_BIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       send,
  input  wire logic [8:0] send_data,
  output logic            ready,
  output logic            txd,
  output logic            txd_oe
);
  import slb_pkg::*;

  slb_tx_regs_t q;
  slb_tx_regs_t next_q;

  assign ready  = (q.st == TX_IDLE);
  assign txd    = q.txd;
  assign txd_oe = q.oe;

  //////////////////////////////////////////////////////////////////////////////
  // eleven bit frame, driver enabled only while shifting
  always_comb begin
    next_q = q;
    unique case (q.st)
      TX_IDLE: begin
        next_q.txd = 1'b1;
        next_q.oe  = 1'b0;
        if (send) begin
          next_q.shift = {1'b1, send_data, 1'b0};
          next_q.txd   = 1'b0;
          next_q.oe    = 1'b1;
          next_q.cnt   = 16'h0000;
          next_q.bitn  = 4'h0;
          next_q.st    = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        next_q.cnt = q.cnt + 16'h0001;
        if (q.cnt == 16'(BIT_CYCLES - 1)) begin
          next_q.cnt   = 16'h0000;
          next_q.shift = {1'b1, q.shift[10:1]};
          next_q.txd   = q.shift[1];
          next_q.bitn  = q.bitn + 4'h1;
          if (q.bitn == 4'(`SLB_DATA_BITS + 1)) begin
            next_q.st  = TX_IDLE;
            next_q.txd = 1'b1;
            next_q.oe  = 1'b0;
          end
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '{st: TX_IDLE, cnt: 16'h0000, bitn: 4'h0, shift: 11'h7FF,
             txd: 1'b1, oe: 1'b0};
    end else begin
      q <= next_q;
    end
  end
endmodule

// File: verilog/slb_responder.sv
// lamp side command interpreter and status responder with apb registers
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "slb_defs.svh"
//
// Function
// - lamp command toggles lamp on state
// - focus runs only while command repeats
// - one home command drives to home
// - record command toggles recording
// - play toggles replay; joystick ends replay
// - store home saves present position
// - accept at most ten bytes per sequence
// - checksum is address plus command bytes
// - pan position sets absolute pan target
// - tilt position sets absolute tilt target
// - position low byte first, high nibble
// - own poll answers six bytes in order
// - reply starts and continues within 1 ms
// - pan and tilt twelve bits, centre 2048
// - status byte bits as defined
// - reply checksum is address plus bytes
// - joystick motion only while repeated
// - eleven bit frame, lsb first
// - bit 8 marks address words
// - fixed 38.4 kilobaud link
module slb_responder #(
  parameter int BIT_CYCLES  = `SLB_BIT_CYCLES,
  parameter int GAP_CYCLES  = `SLB_GAP_CYCLES,
  parameter int HOLD_CYCLES = `SLB_HOLD_CYCLES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        BUS_RXD,
  output logic             BUS_TXD,
  output logic             BUS_TXD_OE,
  output logic             LAMP_ON,
  output logic             FOCUS_RUN,
  output logic             RECORDING,
  output logic             PLAYING,
  output logic             HOMING
);
  import slb_pkg::*;

  typedef struct packed {
    slb_phase_t      phase;
    logic            panel_slot;
    logic            pend;
    logic            ovf;
    logic [3:0]      n;
    logic [8:0][7:0] buff;
    logic [7:0]      sum;
    logic [31:0]     gap;
    logic [3:0]      ip;
    logic [2:0]      rix;
    logic [7:0]      rsum;
    logic            tx_go;
    logic [8:0]      tx_word;
    logic            lamp_on;
    logic            recording;
    logic            playing;
    logic            homing;
    logic [31:0]     focus_t;
    logic [31:0]     pan_jog_t;
    logic [31:0]     tilt_jog_t;
    logic [7:0]      pan_spd;
    logic [7:0]      tilt_spd;
    logic [11:0]     pan_tgt;
    logic [11:0]     tilt_tgt;
    logic [11:0]     home_pan;
    logic [11:0]     home_tilt;
    logic [5:0]      lamp_addr;
    logic [11:0]     pos_pan;
    logic [11:0]     pos_tilt;
    logic            pan_lim;
    logic            tilt_lim;
    logic            hot;
    logic [15:0]     err_cnt;
    logic [31:0]     prdata;
  } slb_top_regs_t;

  slb_top_regs_t q;
  slb_top_regs_t next_q;
  logic          rx_valid;
  logic [8:0]    rx_word;
  logic          tx_ready;
  logic [7:0]    own;
  logic [7:0]    status;
  logic [7:0]    code;
  logic [7:0]    arg1;
  logic [7:0]    arg2;
  logic [7:0]    last;
  logic          wr;
  logic          mapped;

  //////////////////////////////////////////////////////////////////////////////
  // serial word engines on the shared bus pair
  slb_word_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .clk        (SYS_CLK),
    .reset      (RESET),
    .rxd        (BUS_RXD),
    .word_valid (rx_valid),
    .word_data  (rx_word)
  );

  slb_word_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
    .clk       (SYS_CLK),
    .reset     (RESET),
    .send      (q.tx_go),
    .send_data (q.tx_word),
    .ready     (tx_ready),
    .txd       (BUS_TXD),
    .txd_oe    (BUS_TXD_OE)
  );

  //////////////////////////////////////////////////////////////////////////////
  // derived views of the state
  assign own    = {2'b00, q.lamp_addr};
  assign status = {1'b0, q.homing, q.hot, q.playing, q.recording,
                   q.tilt_lim, q.pan_lim, q.lamp_on};
  assign code   = q.buff[q.ip];
  assign arg1   = q.buff[4'(q.ip + 4'h1)];
  assign arg2   = q.buff[4'(q.ip + 4'h2)];
  assign last   = q.buff[4'(q.n - 4'h1)];
  assign wr     = PSEL && PENABLE && PWRITE;
  assign mapped = (PADDR <= `SLB_REG_ERRORS) && (PADDR[1:0] == 2'b00);

  // zero wait state slave; unmapped or misaligned words answer with an error
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && !mapped;
  assign PRDATA    = q.prdata;
  assign LAMP_ON   = q.lamp_on;
  assign FOCUS_RUN = (q.focus_t != 32'h0000_0000);
  assign RECORDING = q.recording;
  assign PLAYING   = q.playing;
  assign HOMING    = q.homing;

  //////////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb begin
    next_q       = q;
    next_q.tx_go = 1'b0;

    // hold timers let focus and joystick motion lapse once repeats stop
    if (q.focus_t != 32'h0000_0000) next_q.focus_t = q.focus_t - 32'h1;
    if (q.pan_jog_t != 32'h0000_0000) next_q.pan_jog_t = q.pan_jog_t - 32'h1;
    if (q.tilt_jog_t != 32'h0000_0000) next_q.tilt_jog_t = q.tilt_jog_t - 32'h1;

    // homing ends when the reported position reaches the stored home
    if (q.homing && q.pos_pan == q.home_pan && q.pos_tilt == q.home_tilt) begin
      next_q.homing = 1'b0;
    end

    // apb register writes in the access cycle, read data capture in the setup cycle
    if (wr) begin
      unique case (PADDR)
        `SLB_REG_CTRL: next_q.lamp_addr = PWDATA[5:0];
        `SLB_REG_POSITION: begin
          next_q.pos_pan  = PWDATA[11:0];
          next_q.pos_tilt = PWDATA[27:16];
        end
        `SLB_REG_FLAGS: begin
          next_q.pan_lim  = PWDATA[0];
          next_q.tilt_lim = PWDATA[1];
          next_q.hot      = PWDATA[2];
        end
        default: ;
      endcase
    end
    if (PSEL && !PENABLE) begin
      unique case (PADDR)
        `SLB_REG_CTRL:     next_q.prdata = {26'h0, q.lamp_addr};
        `SLB_REG_POSITION: next_q.prdata = {4'h0, q.pos_tilt, 4'h0, q.pos_pan};
        `SLB_REG_FLAGS:    next_q.prdata = {29'h0, q.hot, q.tilt_lim, q.pan_lim};
        `SLB_REG_STATE:    next_q.prdata = {21'h0, q.tilt_jog_t != 32'h0,
                                            q.pan_jog_t != 32'h0, FOCUS_RUN, status};
        `SLB_REG_TARGET:   next_q.prdata = {4'h0, q.tilt_tgt, 4'h0, q.pan_tgt};
        `SLB_REG_JOG:      next_q.prdata = {16'h0, q.tilt_spd, q.pan_spd};
        `SLB_REG_ERRORS:   next_q.prdata = {16'h0, q.err_cnt};
        default:           next_q.prdata = 32'h0000_0000;
      endcase
    end

    // sequence phases
    unique case (q.phase)
      PH_IDLE: begin
        if (q.pend) begin
          next_q.pend  = 1'b0;
          next_q.phase = PH_REPLY;
          next_q.rix   = 3'h0;
          next_q.rsum  = own;
        end
      end
      PH_COLLECT: begin
        next_q.gap = q.gap + 32'h1;
        if (rx_valid && !rx_word[`SLB_ADDR_FLAG]) begin
          next_q.gap = 32'h0000_0000;
          if (q.n == 4'(`SLB_MAX_SEQ - 1)) begin
            next_q.ovf = 1'b1;
          end else begin
            next_q.buff[q.n] = rx_word[7:0];
            next_q.n         = q.n + 4'h1;
            next_q.sum       = q.sum + rx_word[7:0];
          end
        end
        // an address word or a silent gap closes the sequence
        if ((rx_valid && rx_word[`SLB_ADDR_FLAG]) || q.gap == 32'(GAP_CYCLES - 1)) begin
          if (!q.ovf && q.n >= 4'h2 && (q.sum - last) == last) begin
            next_q.phase = PH_EXEC;
            next_q.ip    = 4'h0;
          end else begin
            next_q.phase   = PH_IDLE;
            next_q.err_cnt = q.err_cnt + 16'h0001;
          end
        end
      end
      PH_EXEC: begin
        next_q.ip = q.ip + 4'h1;
        if (q.ip >= 4'(q.n - 4'h1)) begin
          next_q.phase = PH_IDLE;
        end else begin
          case (code)
            `SLB_CMD_PAN_JOG, `SLB_CMD_TILT_JOG: begin
              if (4'(q.ip + 4'h1) >= 4'(q.n - 4'h1)) begin
                next_q.phase = PH_IDLE;
              end else begin
                next_q.ip      = q.ip + 4'h2;
                next_q.playing = 1'b0;
                next_q.homing  = 1'b0;
                if (code == `SLB_CMD_PAN_JOG) begin
                  next_q.pan_spd   = arg1;
                  next_q.pan_jog_t = 32'(HOLD_CYCLES);
                end else begin
                  next_q.tilt_spd   = arg1;
                  next_q.tilt_jog_t = 32'(HOLD_CYCLES);
                end
              end
            end
            `SLB_CMD_LAMP:   next_q.lamp_on   = !q.lamp_on;
            `SLB_CMD_FOCUS:  next_q.focus_t   = 32'(HOLD_CYCLES);
            `SLB_CMD_RECORD: next_q.recording = !q.recording;
            `SLB_CMD_PLAY:   next_q.playing   = !q.playing;
            `SLB_CMD_HOME: begin
              next_q.homing   = 1'b1;
              next_q.pan_tgt  = q.home_pan;
              next_q.tilt_tgt = q.home_tilt;
            end
            `SLB_CMD_STORE: begin
              next_q.home_pan  = q.pos_pan;
              next_q.home_tilt = q.pos_tilt;
            end
            `SLB_CMD_PAN_POS, `SLB_CMD_TILT_POS: begin
              if (4'(q.ip + 4'h2) >= 4'(q.n - 4'h1)) begin
                next_q.phase = PH_IDLE;
              end else begin
                next_q.ip     = q.ip + 4'h3;
                next_q.homing = 1'b0;
                if (code == `SLB_CMD_PAN_POS) begin
                  next_q.pan_tgt = {arg2[3:0], arg1};
                end else begin
                  next_q.tilt_tgt = {arg2[3:0], arg1};
                end
              end
            end
            // an unknown code hides the length of what follows, so stop
            default: next_q.phase = PH_IDLE;
          endcase
        end
      end
      PH_REPLY: begin
        if (tx_ready && !q.tx_go) begin
          next_q.tx_go = 1'b1;
          case (q.rix)
            3'h0:    next_q.tx_word = {1'b0, q.pos_pan[7:0]};
            3'h1:    next_q.tx_word = {5'h00, q.pos_pan[11:8]};
            3'h2:    next_q.tx_word = {1'b0, q.pos_tilt[7:0]};
            3'h3:    next_q.tx_word = {5'h00, q.pos_tilt[11:8]};
            3'h4:    next_q.tx_word = {1'b0, status};
            default: next_q.tx_word = {1'b0, q.rsum};
          endcase
          next_q.rsum = q.rsum + next_q.tx_word[7:0];
          next_q.rix  = q.rix + 3'h1;
          if (q.rix == `SLB_REPLY_LAST) begin
            next_q.phase = PH_IDLE;
          end
        end
      end
    endcase

    // address words: panel slots arm a command header, otherwise a poll;
    // our own echo is harmless because reply words carry bit 8 clear; address words, like data words, are ignored while replying
    if (rx_valid && rx_word[`SLB_ADDR_FLAG] && q.phase != PH_REPLY) begin
      if (rx_word[7:0] < `SLB_PANEL_TOP) begin
        next_q.panel_slot = 1'b1;
      end else begin
        next_q.panel_slot = 1'b0;
        if (rx_word[7:0] == own) begin
          if (q.panel_slot) begin
            if (q.phase == PH_IDLE && !q.pend) begin
              next_q.phase = PH_COLLECT;
              next_q.n     = 4'h0;
              next_q.ovf   = 1'b0;
              next_q.gap   = 32'h0000_0000;
              next_q.sum   = rx_word[7:0];
            end
          end else begin
            next_q.pend = 1'b1;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      q           <= '0;
      q.phase     <= PH_IDLE;
      q.pan_spd   <= `SLB_SPEED_CENTRE;
      q.tilt_spd  <= `SLB_SPEED_CENTRE;
      q.pan_tgt   <= `SLB_POS_CENTRE;
      q.tilt_tgt  <= `SLB_POS_CENTRE;
      q.home_pan  <= `SLB_POS_CENTRE;
      q.home_tilt <= `SLB_POS_CENTRE;
      q.pos_pan   <= `SLB_POS_CENTRE;
      q.pos_tilt  <= `SLB_POS_CENTRE;
      q.lamp_addr <= `SLB_LAMP_ADDR_RST;
      q.tx_word   <= 9'h000;
    end else begin
      q <= next_q;
    end
  end
endmodule

// File: tb/slb_responder_checker.sv
// port assertions for the lamp bus responder
`timescale 1ns/1ps
module slb_responder_checker #(
  parameter int BIT_CYCLES  = 16,
  parameter int HOLD_CYCLES = 2000
) (
  input wire logic        SYS_CLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        BUS_TXD,
  input wire logic        BUS_TXD_OE,
  input wire logic        LAMP_ON,
  input wire logic        FOCUS_RUN,
  input wire logic        RECORDING,
  input wire logic        PLAYING,
  input wire logic        HOMING
);
  localparam int WORD_MIN = 11 * BIT_CYCLES - 2;
  int oe_run;
  int foc_run;
  // run lengths, since the fixed repetition limit cannot span a word
  always_ff @(posedge SYS_CLK) begin
    oe_run  <= (RESET || !BUS_TXD_OE) ? 0 : oe_run + 1;
    foc_run <= (RESET || !FOCUS_RUN) ? 0 : foc_run + 1;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sequence start_low;
    !BUS_TXD [*8];
  endsequence
  sequence apb_access;
    PSEL && PENABLE;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  reset_values_a: assert property (disable iff (1'b0) RESET |=> PRDATA == 32'h0
    && BUS_TXD && !BUS_TXD_OE && !LAMP_ON && !FOCUS_RUN && !RECORDING && !PLAYING && !HOMING)
    else $error("outputs not cleared by reset");
  pready_high_a: assert property (apb_access |-> PREADY)
    else $error("pready low in access");
  slverr_bad_a: assert property (PSEL && PENABLE && (PADDR > 8'h18 || PADDR[1:0] != 2'h0)
    |-> PSLVERR) else $error("no error on bad address");
  slverr_good_a: assert property (PSEL && PENABLE && PADDR <= 8'h18 && PADDR[1:0] == 2'h0
    |-> !PSLVERR) else $error("error on mapped address");
  prdata_stands_a: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
    else $error("read data moved outside setup");
  idle_high_a: assert property (!BUS_TXD_OE |-> BUS_TXD)
    else $error("released line not high");
  start_bit_a: assert property ($rose(BUS_TXD_OE) |-> start_low)
    else $error("start bit missing");
  stop_bit_a: assert property ($fell(BUS_TXD_OE) |-> $past(BUS_TXD))
    else $error("stop bit missing");
  word_length_a: assert property ($fell(BUS_TXD_OE) |-> oe_run >= WORD_MIN)
    else $error("reply word too short");
  focus_hold_a: assert property ($fell(FOCUS_RUN) |-> foc_run >= HOLD_CYCLES - 2)
    else $error("focus stopped early");
endmodule

// File: tb/slb_panel_model.sv
// behavioural panel on the far side of the lamp bus
`timescale 1ns/1ps
module slb_panel_model #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic clk,
  input  wire logic line,
  input  wire logic dut_oe,
  output logic      pnl_txd,
  output logic      pnl_oe
);
  logic [8:0] rx_q[$];
  logic [8:0] w;
  initial begin
    pnl_txd = 1'b1;
    pnl_oe  = 1'b0;
  end
  // start, nine bits lsb first, stop; the line stays driven until idle
  task automatic send_word(input logic [8:0] d);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      pnl_txd <= f[i];
      pnl_oe  <= 1'b1;
      repeat (BIT_CYCLES) @(posedge clk);
    end
  endtask
  task automatic idle();
    pnl_oe  <= 1'b0;
    pnl_txd <= 1'b1;
  endtask
  // reply words sampled at mid bit while the lamp drives
  initial forever begin
    @(posedge clk);
    if (dut_oe === 1'b1 && line === 1'b0) begin
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYCLES) @(posedge clk);
        w[i] = line;
      end
      repeat (BIT_CYCLES) @(posedge clk);
      rx_q.push_back(w);
    end
  end
endmodule

// File: tb/slb_responder_tb.sv
// self-checking bench for the lamp bus responder
`timescale 1ns/1ps
module slb_responder_tb;
  localparam int BIT_CYCLES  = 16;
  localparam int GAP_CYCLES  = 400;
  localparam int HOLD_CYCLES = 2000;
  logic        SYS_CLK, RESET, PSEL, PENABLE, PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, rd;
  logic        err;
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, BUS_TXD, BUS_TXD_OE, LAMP_ON, FOCUS_RUN;
  wire         RECORDING, PLAYING, HOMING, pnl_txd, pnl_oe, bus_line;
  int          fail_count = 0;
  int          samples_checked = 0;
  // fail-safe bias holds the released line high
  assign bus_line = BUS_TXD_OE ? BUS_TXD : (pnl_oe ? pnl_txd : 1'b1);
  slb_responder #(.BIT_CYCLES(BIT_CYCLES), .GAP_CYCLES(GAP_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES)) slb_responder_inst (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BUS_RXD(bus_line),
    .BUS_TXD(BUS_TXD), .BUS_TXD_OE(BUS_TXD_OE), .LAMP_ON(LAMP_ON), .FOCUS_RUN(FOCUS_RUN),
    .RECORDING(RECORDING), .PLAYING(PLAYING), .HOMING(HOMING));
  slb_panel_model #(.BIT_CYCLES(BIT_CYCLES)) slb_panel_model_inst (.clk(SYS_CLK),
    .line(bus_line), .dut_oe(BUS_TXD_OE), .pnl_txd(pnl_txd), .pnl_oe(pnl_oe));
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      fail_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // one apb transfer, held until pready; an idle edge follows
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'b1) @(posedge SYS_CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  // panel 0 slot, lamp header, commands, checksum, then silence
  task automatic send_seq(input logic [7:0] b[$], input logic [7:0] bad);
    logic [7:0] s;
    s = 8'h10;
    slb_panel_model_inst.send_word(9'h100);
    slb_panel_model_inst.send_word(9'h110);
    foreach (b[i]) begin
      slb_panel_model_inst.send_word({1'b0, b[i]});
      s += b[i];
    end
    slb_panel_model_inst.send_word({1'b0, s + bad});
    slb_panel_model_inst.idle();
    repeat (GAP_CYCLES + 40) @(posedge SYS_CLK);
  endtask
  task automatic poll(input logic [11:0] pan, input logic [11:0] tlt, input logic [7:0] st);
    logic [7:0] e[6];
    int n;
    e = '{pan[7:0], {4'h0, pan[11:8]}, tlt[7:0], {4'h0, tlt[11:8]}, st, 8'h10};
    for (n = 0; n < 5; n++) e[5] += e[n];
    slb_panel_model_inst.rx_q.delete();
    slb_panel_model_inst.send_word(9'h110);
    slb_panel_model_inst.idle();
    n = 0;
    while (BUS_TXD_OE !== 1'b1 && n < GAP_CYCLES) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk(n < GAP_CYCLES, "reply start late");
    n = 0;
    while (slb_panel_model_inst.rx_q.size() < 6 && n < 66 * BIT_CYCLES + 60) begin
      @(posedge SYS_CLK);
      n++;
    end
    for (n = 0; n < 6; n++) chk(slb_panel_model_inst.rx_q[n] === {1'b0, e[n]}, "reply");
    repeat (2 * BIT_CYCLES) @(posedge SYS_CLK);
  endtask
  initial begin
    repeat (60000) @(posedge SYS_CLK);
    fail_count++;
    give_verdict();
  end
  initial begin
    {RESET, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {4'b1000, 8'h00, 32'h0};
    repeat (5) @(posedge SYS_CLK);
    RESET <= 1'b0;
    @(posedge SYS_CLK);
    chk(BUS_TXD === 1'b1 && BUS_TXD_OE === 1'b0 && LAMP_ON === 1'b0, "reset state");
    apb(1'b0, 8'h00, 32'h0);
    chk(rd === 32'h10 && err === 1'b0, "lamp address reset");
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd === 32'h0 && err === 1'b1, "unmapped read");
    apb(1'b1, 8'h04, 32'h07D0_09A4);
    poll(12'h9A4, 12'h7D0, 8'h00);
    send_seq('{8'h0A}, 8'h00);
    chk(LAMP_ON === 1'b1, "lamp toggle");
    send_seq('{8'h0A}, 8'h01);
    chk(LAMP_ON === 1'b1, "bad checksum obeyed");
    send_seq('{8'h05}, 8'h00);
    chk(LAMP_ON === 1'b1, "unknown code obeyed");
    apb(1'b0, 8'h18, 32'h0);
    chk(rd === 32'h1, "discard count");
    apb(1'b1, 8'h08, 32'h7);
    poll(12'h9A4, 12'h7D0, 8'h27);
    send_seq('{8'h0D, 8'h0E}, 8'h00);
    chk(RECORDING === 1'b1 && PLAYING === 1'b1, "record and play");
    poll(12'h9A4, 12'h7D0, 8'h3F);
    send_seq('{8'h01, 8'hA0}, 8'h00);
    chk(PLAYING === 1'b0 && RECORDING === 1'b1, "joystick ends replay");
    send_seq('{8'h0D}, 8'h00);
    chk(RECORDING === 1'b0, "record off");
    send_seq('{8'h0E}, 8'h00);
    chk(PLAYING === 1'b1, "play on");
    send_seq('{8'h0E}, 8'h00);
    chk(PLAYING === 1'b0, "play off");
    send_seq('{8'h0B}, 8'h00);
    chk(FOCUS_RUN === 1'b1, "focus run");
    repeat (HOLD_CYCLES) @(posedge SYS_CLK);
    chk(FOCUS_RUN === 1'b0, "focus stop");
    send_seq('{8'h0F}, 8'h00);
    apb(1'b1, 8'h04, 32'h0100_0200);
    send_seq('{8'h0C}, 8'h00);
    chk(HOMING === 1'b1, "homing");
    apb(1'b0, 8'h10, 32'h0);
    chk(rd === 32'h07D0_09A4, "home target");
    apb(1'b1, 8'h04, 32'h07D0_09A4);
    repeat (4) @(posedge SYS_CLK);
    chk(HOMING === 1'b0, "home reached");
    send_seq('{8'h18, 8'hBC, 8'h0A, 8'h19, 8'h23, 8'h01}, 8'h00);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd === 32'h0123_0ABC, "position target");
    send_seq('{8'h01, 8'h80, 8'h02, 8'h80, 8'h0A, 8'h18, 8'h34, 8'h08}, 8'h00);
    chk(LAMP_ON === 1'b0, "longest sequence");
    send_seq('{8'h01, 8'h80, 8'h02, 8'h80, 8'h0A, 8'h18, 8'h00, 8'h08, 8'h0B}, 8'h00);
    chk(LAMP_ON === 1'b0 && FOCUS_RUN === 1'b0, "overlong obeyed");
    apb(1'b0, 8'h18, 32'h0);
    chk(rd === 32'h2, "overlong count");
    apb(1'b0, 8'h10, 32'h0);
    chk(rd === 32'h0123_0834, "target after overlong");
    give_verdict();
  end
endmodule
bind slb_responder slb_responder_checker #(.BIT_CYCLES(BIT_CYCLES),
  .HOLD_CYCLES(HOLD_CYCLES)) chk_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .BUS_TXD(BUS_TXD), .BUS_TXD_OE(BUS_TXD_OE), .LAMP_ON(LAMP_ON), .FOCUS_RUN(FOCUS_RUN),
  .RECORDING(RECORDING), .PLAYING(PLAYING), .HOMING(HOMING));
